// ---- rtl/qsync_defines.vh ----
// Constants and field layout for the queue sync command block
// Overview of operation
// - Completion may raise interrupt or wakeup event
// - Effects observable before signal and index advance
// - Signal visible implies consumer index already advanced
// - Select 00: no action, notify fields ignored
// - Select 01: write payload to nonzero address
// - Without message writes, ignore address and payload
// - Wired interrupt pulses regardless of address value
// - Select 10: wakeup event only if capable
// - Select 11 reserved, report illegal command error
// - Shareability decode, 01 treated as non-shareable
// - Device or non-cacheable attr forces outer shareable
// - Address bits 51:2, single aligned word write
// - Nonzero test spans whole address field
// - Truncate address to implemented output size
// - Wait until all earlier commands complete
// - Hold later commands until sync completes
// - Invalidations done, targeted transactions observable first
// - Software translations finish or restart afterwards
// - Broadcast invalidations need not be awaited
// - Configuration invalidations finished before completion
// - Syncs complete in order, earlier writes visible
// - Pending fault records flushed or discarded first
`ifndef QSYNC_DEFINES_VH
`define QSYNC_DEFINES_VH
`define OPC_LSB 0
`define OPC_MSB 7
`define OPC_SYNC 8'h46
`define CS_LSB 12
`define CS_MSB 13
`define SH_LSB 22
`define SH_MSB 23
`define ATTR_LSB 24
`define ATTR_MSB 27
`define CS_NONE 2'h0
`define CS_IRQ 2'h1
`define CS_SEV 2'h2
`define CS_RSVD 2'h3
`define SH_NON 2'h0
`define SH_RSVD 2'h1
`define SH_OUTER 2'h2
`define SH_INNER 2'h3
`define ATTR_NC 4'h5
`define ATTR_DEV_TOP 4'h3
`define ADDR_W 50
`define ADDR_HI_W 20
`define WB_ADR_W 8
`define A_W0 8'h00
`define A_W1 8'h04
`define A_W2 8'h08
`define A_W3 8'h0C
`define A_CTRL 8'h10
`define A_STAT 8'h14
`define A_CONS 8'h18
`define A_CAPS 8'h1C
`define CTRL_GO 0
`define CTRL_ERRCLR 1
`define ST_BUSY 0
`define ST_ERR 1
`define CONS_W 16
`define PULSE_TIME_NS 8
`define CLK_NS 4
`define PULSE_CYC ((`PULSE_TIME_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ---- rtl/qsync_wordmem.v ----
// Small register array holding the four command words
`timescale 1ns/100ps
module qsync_wordmem #(
  parameter DEPTH = 4,
  parameter AW = 2
)(
  input wire clk,
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [31:0] wdata,
  input wire [AW-1:0] raddr,
  output reg [31:0] rdata
);
  reg [31:0] mem [0:DEPTH-1];
  always @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // qsync_wordmem

// ---- rtl/queue_sync_command.v ----
// Queue sync command interpreter with Wishbone register access
`timescale 1ns/100ps
`include "qsync_defines.vh"
module queue_sync_command #(
  parameter OUTPUT_ADDRESS_SIZE = 48,
  parameter MSG_WRITE_OK = 1,
  parameter WIRED_IRQ_OK = 1,
  parameter WAKE_EVENT_CAPABLE = 1
)(
  input wire CLK,
  input wire SYS_RST,
  input wire [`WB_ADR_W-1:0] WB_ADR_I,
  input wire [31:0] WB_DAT_I,
  input wire [3:0] WB_SEL_I,
  input wire WB_WE_I,
  input wire WB_CYC_I,
  input wire WB_STB_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  output reg WB_ERR_O,
  input wire PRIOR_IDLE,
  input wire FAULTS_FLUSHED,
  output reg HOLD_LATER,
  output reg DRAIN_REQ,
  output reg NOTIFY_VALID,
  output reg [51:0] NOTIFY_ADDR,
  output reg [31:0] NOTIFY_DATA,
  output reg [3:0] NOTIFY_ATTR,
  output reg [1:0] NOTIFY_SH,
  input wire NOTIFY_READY,
  input wire NOTIFY_DONE,
  output reg WIRED_IRQ,
  output reg WAKE_EVENT,
  output reg ILLEGAL_CMD
);
  localparam S_IDLE = 6'b000001;
  localparam S_LOAD = 6'b000010;
  localparam S_DRAIN = 6'b000100;
  localparam S_WRITE = 6'b001000;
  localparam S_WAITW = 6'b010000;
  localparam S_SIGNAL = 6'b100000;
  localparam integer PULSE_LOAD = `PULSE_CYC - 1;

  // Shareability decode, attribute override applied
  function [1:0] eff_sh;
    input [1:0] sh;
    input [3:0] attr;
    begin
      if (attr <= `ATTR_DEV_TOP || attr == `ATTR_NC)
      begin
        eff_sh = `SH_OUTER;
      end
      else if (sh == `SH_RSVD)
      begin
        eff_sh = `SH_NON;
      end
      else
      begin
        eff_sh = sh;
      end
    end
  endfunction

  // Register address match for one word
  function hit;
    input [`WB_ADR_W-1:0] a;
    input [`WB_ADR_W-1:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  reg [5:0] state;
  reg [5:0] next_state;
  reg [1:0] ld_idx;
  reg [31:0] w0;
  reg [31:0] w1;
  reg [31:0] w2;
  reg [`CONS_W-1:0] cons;
  reg go_pend;
  reg err;
  reg [1:0] pulse_cnt;
  reg idle_s1;
  reg idle_s2;
  reg flush_s1;
  reg flush_s2;
  wire [31:0] mem_rdata;
  reg cons_step;
  wire req = WB_CYC_I & WB_STB_I & ~WB_ACK_O & ~WB_ERR_O;
  wire wr = req & WB_WE_I;
  wire full_word = (WB_SEL_I == 4'hF);
  wire mapped = (WB_ADR_I[1:0] == 2'h0) && (WB_ADR_I <= `A_CAPS);
  wire wr_cmd = wr & full_word & mapped & (WB_ADR_I[`WB_ADR_W-1:4] == 4'h0) & state[0];
  wire wr_ctrl = wr & hit(WB_ADR_I, `A_CTRL) & WB_SEL_I[0];
  wire [7:0] opc = w0[`OPC_MSB:`OPC_LSB];
  wire [1:0] cs = w0[`CS_MSB:`CS_LSB];
  wire [1:0] sh = w0[`SH_MSB:`SH_LSB];
  wire [3:0] attr = w0[`ATTR_MSB:`ATTR_LSB];
  wire bad_cmd = (opc != `OPC_SYNC) || (cs == `CS_RSVD);
  wire prior_done = idle_s2 & flush_s2;
  wire [`ADDR_W-1:0] addr_field = {mem_rdata[`ADDR_HI_W-1:0], w2[31:2]};
  wire addr_nz = |addr_field;
  wire [51:0] addr_full = {addr_field, 2'h0};
  wire [51:0] oas_mask = (OUTPUT_ADDRESS_SIZE >= 52) ? {52{1'b1}} : ((52'h1 << OUTPUT_ADDRESS_SIZE) - 52'h1);

  qsync_wordmem #(.DEPTH(4), .AW(2)) u_words (
    .clk(CLK),
    .we(wr_cmd),
    .waddr(WB_ADR_I[3:2]),
    .wdata(WB_DAT_I),
    .raddr(ld_idx),
    .rdata(mem_rdata)
  );

  // Synchronise status from other logic
  always @(posedge CLK)
  begin
    idle_s1 <= PRIOR_IDLE;
    idle_s2 <= idle_s1;
    flush_s1 <= FAULTS_FLUSHED;
    flush_s2 <= flush_s1;
  end

  // Bus slave
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      WB_ACK_O <= 1'b0;
      WB_ERR_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end
    else
    begin
      WB_ACK_O <= req & mapped;
      WB_ERR_O <= req & ~mapped;
      WB_DAT_O <= 32'h0000_0000;
      if (req & ~WB_WE_I)
      begin
        case (WB_ADR_I)
          `A_STAT: WB_DAT_O <= {30'h0, err, ~state[0]};
          `A_CONS: WB_DAT_O <= {{(32-`CONS_W){1'b0}}, cons};
          `A_CAPS: WB_DAT_O <= {29'h0, WAKE_EVENT_CAPABLE[0], WIRED_IRQ_OK[0],
                                MSG_WRITE_OK[0]};
          default: WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  always @*
  begin
    next_state = state;
    case (state)
      S_IDLE:
        if (go_pend)
        begin
          next_state = S_LOAD;
        end
      S_LOAD:
        if (ld_idx == 2'h3)
        begin
          next_state = S_DRAIN;
        end
      S_DRAIN:
        if (bad_cmd)
        begin
          next_state = S_IDLE;
        end
        else if (prior_done)
        begin
          if (cs == `CS_IRQ && MSG_WRITE_OK != 0 && addr_nz)
          begin
            next_state = S_WRITE;
          end
          else
          begin
            next_state = S_SIGNAL;
          end
        end
      S_WRITE:
        if (NOTIFY_READY)
        begin
          next_state = S_WAITW;
        end
      S_WAITW:
        if (NOTIFY_DONE)
        begin
          next_state = S_SIGNAL;
        end
      S_SIGNAL:
        next_state = S_IDLE;
      default:
        next_state = S_IDLE;
    endcase
  end

  // Sequencer, word capture and consumer index
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      state <= S_IDLE;
      ld_idx <= 2'h0;
      w0 <= 32'h0000_0000;
      w1 <= 32'h0000_0000;
      w2 <= 32'h0000_0000;
      cons <= {`CONS_W{1'b0}};
      HOLD_LATER <= 1'b0;
      DRAIN_REQ <= 1'b0;
      ILLEGAL_CMD <= 1'b0;
    end
    else
    begin
      state <= next_state;
      ILLEGAL_CMD <= 1'b0;
      if (state[0] & go_pend)
      begin
        ld_idx <= 2'h0;
        HOLD_LATER <= 1'b1;
      end
      if (state[1])
      begin
        // Index parks on the last word so its read data stays put while draining
        if (ld_idx != 2'h3)
        begin
          ld_idx <= ld_idx + 2'h1;
        end
        case (ld_idx)
          2'h1: w0 <= mem_rdata;
          2'h2: w1 <= mem_rdata;
          2'h3: w2 <= mem_rdata;
          default: w0 <= w0;
        endcase
      end
      DRAIN_REQ <= state[2] && next_state == S_DRAIN;
      if (state[2] && bad_cmd)
      begin
        ILLEGAL_CMD <= 1'b1;
        HOLD_LATER <= 1'b0;
      end
      // Index advances first; signal follows a cycle later
      if (state[5])
      begin
        cons <= cons + {{(`CONS_W-1){1'b0}}, 1'b1};
        HOLD_LATER <= 1'b0;
      end
    end
  end

  // Start request and sticky error flag
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      go_pend <= 1'b0;
      err <= 1'b0;
    end
    else
    begin
      if (wr_ctrl && WB_DAT_I[`CTRL_GO] && state[0])
      begin
        go_pend <= 1'b1;
      end
      else if (state[1])
      begin
        go_pend <= 1'b0;
      end
      // A new error outranks a clear in the same cycle
      if (wr_ctrl && WB_DAT_I[`CTRL_ERRCLR])
      begin
        err <= 1'b0;
      end
      if (state[2] && bad_cmd)
      begin
        err <= 1'b1;
      end
    end
  end

  // Notify write request, held until accepted
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      NOTIFY_VALID <= 1'b0;
      NOTIFY_ADDR <= 52'h0_0000_0000_0000;
      NOTIFY_DATA <= 32'h0000_0000;
      NOTIFY_ATTR <= 4'h0;
      NOTIFY_SH <= 2'h0;
    end
    else
    begin
      if (state[2] && next_state == S_WRITE)
      begin
        NOTIFY_VALID <= 1'b1;
        NOTIFY_ADDR <= addr_full & oas_mask;
        NOTIFY_DATA <= w1;
        NOTIFY_ATTR <= attr;
        NOTIFY_SH <= eff_sh(sh, attr);
      end
      if (state[3] & NOTIFY_READY)
      begin
        NOTIFY_VALID <= 1'b0;
      end
    end
  end

  // Completion signals, one cycle after the consumer index moves
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      cons_step <= 1'b0;
      pulse_cnt <= 2'h0;
      WIRED_IRQ <= 1'b0;
      WAKE_EVENT <= 1'b0;
    end
    else
    begin
      cons_step <= state[5];
      WAKE_EVENT <= 1'b0;
      if (pulse_cnt != 2'h0)
      begin
        pulse_cnt <= pulse_cnt - 2'h1;
      end
      else
      begin
        WIRED_IRQ <= 1'b0;
      end
      if (state[0] && cons_step)
      begin
        if (cs == `CS_IRQ && WIRED_IRQ_OK != 0)
        begin
          WIRED_IRQ <= 1'b1;
          pulse_cnt <= PULSE_LOAD[1:0];
        end
        if (cs == `CS_SEV && WAKE_EVENT_CAPABLE != 0)
        begin
          WAKE_EVENT <= 1'b1;
        end
      end
    end
  end
endmodule // queue_sync_command

// ---- dv/qsync_asserts.sv ----
// Port assertions for the queue sync command block
`timescale 1ns/100ps
module qsync_asserts #(
  parameter OUTPUT_ADDRESS_SIZE = 48
)(
  input wire CLK,
  input wire SYS_RST,
  input wire PRIOR_IDLE,
  input wire HOLD_LATER,
  input wire DRAIN_REQ,
  input wire NOTIFY_VALID,
  input wire NOTIFY_READY,
  input wire [51:0] NOTIFY_ADDR,
  input wire [31:0] NOTIFY_DATA,
  input wire [3:0] NOTIFY_ATTR,
  input wire [1:0] NOTIFY_SH,
  input wire WIRED_IRQ,
  input wire WAKE_EVENT
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  property p_irq_order;
    $rose(WIRED_IRQ) |-> !HOLD_LATER && $past(HOLD_LATER, 2);
  endproperty
  a_irq_order: assert property (p_irq_order) else $error("irq before consume");
  property p_wake;
    $rose(WAKE_EVENT) |-> (!HOLD_LATER && $past(HOLD_LATER, 2)) ##1 !WAKE_EVENT;
  endproperty
  a_wake: assert property (p_wake) else $error("bad wake pulse");
  property p_irq_len;
    $rose(WIRED_IRQ) |=> WIRED_IRQ ##1 !WIRED_IRQ;
  endproperty
  a_irq_len: assert property (p_irq_len) else $error("bad irq pulse");
  property p_notify_hold;
    NOTIFY_VALID && !NOTIFY_READY |=>
      NOTIFY_VALID && $stable(NOTIFY_ADDR) && $stable(NOTIFY_DATA);
  endproperty
  a_notify_hold: assert property (p_notify_hold) else $error("notify dropped");
  property p_notify_addr;
    NOTIFY_VALID |-> NOTIFY_ADDR[1:0] == 2'b00 && (NOTIFY_ADDR >> OUTPUT_ADDRESS_SIZE) == 0;
  endproperty
  a_notify_addr: assert property (p_notify_addr) else $error("bad address");
  property p_sh_rsvd;
    NOTIFY_VALID |-> NOTIFY_SH != 2'b01;
  endproperty
  a_sh_rsvd: assert property (p_sh_rsvd) else $error("reserved sharing");
  property p_sh_outer;
    NOTIFY_VALID && (NOTIFY_ATTR <= 4'h3 || NOTIFY_ATTR == 4'h5) |-> NOTIFY_SH == 2'b10;
  endproperty
  a_sh_outer: assert property (p_sh_outer) else $error("not outer");
  property p_drain_hold;
    DRAIN_REQ |-> HOLD_LATER;
  endproperty
  a_drain_hold: assert property (p_drain_hold) else $error("later not held");
  property p_prior_wait;
    (!PRIOR_IDLE) [*6] |-> !$rose(NOTIFY_VALID) && !$rose(WIRED_IRQ) && !$rose(WAKE_EVENT);
  endproperty
  a_prior_wait: assert property (p_prior_wait) else $error("early completion");
endmodule // qsync_asserts
bind queue_sync_command qsync_asserts #(.OUTPUT_ADDRESS_SIZE(OUTPUT_ADDRESS_SIZE)) qsync_asserts_i (.CLK(CLK),
  .SYS_RST(SYS_RST), .PRIOR_IDLE(PRIOR_IDLE), .HOLD_LATER(HOLD_LATER),
  .DRAIN_REQ(DRAIN_REQ), .NOTIFY_VALID(NOTIFY_VALID), .NOTIFY_READY(NOTIFY_READY),
  .NOTIFY_ADDR(NOTIFY_ADDR), .NOTIFY_DATA(NOTIFY_DATA), .NOTIFY_ATTR(NOTIFY_ATTR),
  .NOTIFY_SH(NOTIFY_SH), .WIRED_IRQ(WIRED_IRQ), .WAKE_EVENT(WAKE_EVENT));

// ---- dv/qsync_notify_sink.sv ----
// Memory side model taking notify writes
`timescale 1ns/100ps
module qsync_notify_sink (
  input wire clk,
  input wire rst,
  input wire valid,
  input wire [51:0] addr,
  input wire [31:0] data,
  input wire slow,
  output logic ready,
  output logic done,
  output logic [51:0] got_addr,
  output logic [31:0] got_data,
  output logic [7:0] count
);
  logic [3:0] dly;
  logic pend;
  always @(posedge clk)
  begin
    pend <= valid && ready;
    done <= pend;
    ready <= valid && !ready && (!slow || dly == 4'h3);
    dly <= (valid && !ready) ? dly + 4'h1 : 4'h0;
    if (valid && ready)
    begin
      got_addr <= addr;
      got_data <= data;
      count <= count + 8'h01;
    end
    if (rst)
    begin
      pend <= 1'b0;
      done <= 1'b0;
      ready <= 1'b0;
      dly <= 4'h0;
      count <= 8'h00;
    end
  end
endmodule // qsync_notify_sink

// ---- dv/testbench.sv ----
// Self-checking bench for the queue sync command block
`timescale 1ns/100ps
`include "qsync_defines.vh"
module testbench;
  logic clk = 0;
  logic rst = 1;
  logic cyc = 0, stb = 0, we = 0, pidle = 1, fflush = 1, slow = 0, werr;
  logic [7:0] adr = 0;
  logic [31:0] wdat = 0, r;
  logic [15:0] cons = 0;
  logic pi = 0, pw = 0, pl = 0;
  wire [31:0] rdat, ndata, gdata;
  wire [51:0] naddr, gaddr;
  wire [7:0] ncount;
  wire [3:0] nattr;
  wire [1:0] nsh;
  logic [3:0] gattr;
  logic [1:0] gsh;
  wire ack, err, hold, nvalid, nready, ndone, irq, wake, ill;
  integer num_errors = 0, n_checks = 0, nirq = 0, nwake = 0, nill = 0;
  queue_sync_command queue_sync_command_i (.CLK(clk), .SYS_RST(rst), .WB_ADR_I(adr),
    .WB_DAT_I(wdat), .WB_SEL_I(4'hF), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .WB_ERR_O(err), .PRIOR_IDLE(pidle),
    .FAULTS_FLUSHED(fflush), .HOLD_LATER(hold), .DRAIN_REQ(), .NOTIFY_VALID(nvalid),
    .NOTIFY_ADDR(naddr), .NOTIFY_DATA(ndata), .NOTIFY_ATTR(nattr), .NOTIFY_SH(nsh),
    .NOTIFY_READY(nready), .NOTIFY_DONE(ndone), .WIRED_IRQ(irq), .WAKE_EVENT(wake),
    .ILLEGAL_CMD(ill));
  qsync_notify_sink qsync_notify_sink_i (.clk(clk), .rst(rst), .valid(nvalid),
    .addr(naddr), .data(ndata), .slow(slow), .ready(nready), .done(ndone),
    .got_addr(gaddr), .got_data(gdata), .count(ncount));
  initial forever #2 clk = ~clk;
  always @(posedge clk)
  begin
    if (irq && !pi) nirq++;
    if (wake && !pw) nwake++;
    if (ill && !pl) nill++;
    pi <= irq;
    pw <= wake;
    pl <= ill;
    if (nvalid && nready)
    begin
      gsh <= nsh;
      gattr <= nattr;
    end
  end
  task chk(input logic [63:0] s, input logic [63:0] e);
    begin
      n_checks++;
      if (s !== e)
      begin
        num_errors++;
        $display("wrong value at %0t: saw %h expected %h", $time, s, e);
      end
    end
  endtask
  function logic [1:0] exp_sh(input logic [1:0] s, input logic [3:0] a);
    if (a <= `ATTR_DEV_TOP || a == `ATTR_NC) return `SH_OUTER;
    return (s == `SH_RSVD) ? `SH_NON : s;
  endfunction
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer k;
    begin
      @(posedge clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      k = 0;
      do
      begin
        @(posedge clk);
        k++;
      end
      while (ack !== 1'b1 && err !== 1'b1 && k < 40);
      r = rdat;
      werr = err;
      cyc <= 0;
      stb <= 0;
      if (k >= 40) num_errors++;
    end
  endtask
  task sync(input logic [1:0] cs, input logic [7:0] opc, input logic [3:0] at,
    input logic [1:0] sh, input logic [31:0] a2, input logic [19:0] a3);
    logic [31:0] pay;
    logic [51:0] full;
    logic bad;
    integer i0, w0, l0, c0, k;
    begin
      pay = $urandom;
      full = {a3, a2[31:2], 2'b00};
      bad = cs == `CS_RSVD || opc != `OPC_SYNC;
      i0 = nirq;
      w0 = nwake;
      l0 = nill;
      c0 = ncount;
      slow <= $urandom;
      wb(1, `A_W0, {4'h0, at, sh, 8'h00, cs, 4'h0, opc});
      wb(1, `A_W1, pay);
      wb(1, `A_W2, a2);
      wb(1, `A_W3, {12'h000, a3});
      pidle <= 0;
      fflush <= $urandom;
      wb(1, `A_CTRL, 32'h0000_0001);
      repeat ($urandom_range(12, 2)) @(posedge clk);
      if (!bad) chk(hold, 1);
      wb(0, `A_CONS, 0);
      chk(r[15:0], cons);
      pidle <= 1;
      fflush <= 1;
      k = 0;
      do
      begin
        wb(0, `A_STAT, 0);
        k++;
      end
      while (r[0] !== 1'b0 && k < 30);
      if (k >= 30) num_errors++;
      chk(r[1], bad);
      if (!bad) cons++;
      wb(0, `A_CONS, 0);
      chk(r[15:0], cons);
      chk(nill - l0, bad);
      chk(nirq - i0, cs == 1 && !bad);
      chk(nwake - w0, cs == 2 && !bad);
      chk(ncount - c0, cs == 1 && !bad && full[51:2] != 0);
      if (ncount != c0)
      begin
        chk(gaddr, full & 52'h0_FFFF_FFFF_FFFF);
        chk(gdata, pay);
        chk(gsh, exp_sh(sh, at));
        chk(gattr, at);
      end
      if (bad) wb(1, `A_CTRL, 32'h0000_0002);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial
  begin
    #100000;
    num_errors++;
    end_sim;
  end
  initial
  begin
    r = $urandom(90);
    repeat (6) @(posedge clk);
    rst <= 0;
    wb(0, 8'h20, 0);
    chk(werr, 1);
    sync(0, 8'h46, 4'hF, 2'h3, 32'hFFFF_FFFF, 20'hF_FFFF);
    sync(1, 8'h46, 4'hF, 2'h1, 32'h0000_0000, 20'h8_0000);
    sync(1, 8'h46, 4'h2, 2'h3, 32'h0000_0040, 20'h0_0000);
    sync(1, 8'h46, 4'hF, 2'h3, 32'h0000_0003, 20'h0_0000);
    sync(2, 8'h46, 4'h5, 2'h0, 32'h0000_0010, 20'h0_0000);
    sync(3, 8'h46, 4'hF, 2'h2, 32'h0000_0010, 20'h0_0000);
    sync(0, 8'h47, 4'hF, 2'h2, 32'h0000_0010, 20'h0_0000);
    repeat (40) sync($urandom, 8'h46, $urandom, $urandom, $urandom, $urandom);
    end_sim;
  end
endmodule // testbench
